// >>> hw/ioc_pkg.sv
`default_nettype none
package ioc_pkg;

  // Port and pointer widths
  localparam int unsigned PORT_WIDTH = 8;
  localparam int unsigned PORT_COUNT = 2;
  localparam int unsigned ADDR_WIDTH = 5;

  // Register index within one port's group
  localparam logic [3:0] IDX_ENABLE = 4'h2;
  localparam logic [3:0] IDX_DEFAULT = 4'h3;
  localparam logic [3:0] IDX_SOURCE = 4'h4;
  localparam logic [3:0] IDX_CONFIG = 4'h5;
  localparam logic [3:0] IDX_FLAG = 4'h7;
  localparam logic [3:0] IDX_CAPTURE = 4'h8;
  localparam logic [3:0] IDX_PORT = 4'h9;
  localparam logic [3:0] IDX_LAST = 4'ha;

  // Address map limits
  localparam logic [4:0] BANK0_LAST_ADDR = 5'h15;
  localparam logic [4:0] POINTER_STEP = 5'h01;

  // Reset values
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] DEFAULT_RESET = 8'h00;
  localparam logic [7:0] SOURCE_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CONFIG_WRITE_MASK = 8'hfe;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [2:0] HW_ADDRESS_ZERO = 3'h0;

  // Configuration register, bit 7 first
  typedef struct packed {
    logic bank;
    logic mirror;
    logic sequential_disable_bit;
    logic slew_disable_bit;
    logic hw_address_enable_bit;
    logic open_drain_bit;
    logic interrupt_polarity_bit;
    logic unused0;
  } config_type;

  // Per-port change-interrupt setup
  typedef struct packed {
    logic [PORT_WIDTH-1:0] enable;
    logic [PORT_WIDTH-1:0] default_value;
    logic [PORT_WIDTH-1:0] source;
  } port_cfg_type;

  // Decoded register selection
  typedef struct packed {
    logic valid;
    logic port;
    logic [3:0] index;
  } reg_sel_type;

endpackage : ioc_pkg
`default_nettype wire

// >>> hw/ioc_port_events.sv
`timescale 1ns/1ns
`default_nettype none
module ioc_port_events (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Setup and pins, already synchronised
  input wire ioc_pkg::port_cfg_type i_cfg,
  input wire logic [ioc_pkg::PORT_WIDTH-1:0] i_pin_level,
  input wire logic [ioc_pkg::PORT_WIDTH-1:0] i_pin_is_input,
  input wire logic i_clear,
  // Results
  output logic [ioc_pkg::PORT_WIDTH-1:0] o_flags,
  output logic [ioc_pkg::PORT_WIDTH-1:0] o_capture,
  output logic o_irq
);

  logic [ioc_pkg::PORT_WIDTH-1:0] prev_q;
  logic prev_valid_q;
  logic [ioc_pkg::PORT_WIDTH-1:0] flags_q;
  logic [ioc_pkg::PORT_WIDTH-1:0] capture_q;
  logic [ioc_pkg::PORT_WIDTH-1:0] ref_level;
  logic [ioc_pkg::PORT_WIDTH-1:0] mismatch;
  logic event_hit;
  logic active;

  // Reference per pin: default value or last sample
  assign ref_level = (i_cfg.source & i_cfg.default_value) | (~i_cfg.source & prev_q);
  // Only enabled input pins compare; no pin-change compare until one sample is held
  always_comb begin
    mismatch = i_cfg.enable & i_pin_is_input & (i_pin_level ^ ref_level);
    if (!prev_valid_q) begin
      mismatch = mismatch & i_cfg.source;
    end
  end
  assign event_hit = |mismatch;
  assign active = |flags_q;

  // Previous-value reference follows every sample
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_q <= '0;
      prev_valid_q <= 1'b0;
    end else if (i_clk_en) begin
      prev_q <= i_pin_level;
      prev_valid_q <= 1'b1;
    end
  end

  // Flags and capture freeze while active; a new event in the clear cycle wins
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags_q <= '0;
      capture_q <= '0;
    end else if (i_clk_en) begin
      if (event_hit && (!active || i_clear)) begin
        flags_q <= mismatch;
        capture_q <= i_pin_level;
      end else if (i_clear) begin
        flags_q <= '0;
      end
    end
  end

  assign o_flags = flags_q;
  assign o_capture = capture_q;
  assign o_irq = active;

endmodule : ioc_port_events
`default_nettype wire

// >>> hw/ioc_config_control.sv
// Operation
// - Enable bit set arms pin change interrupt
// - Default compare: opposite pin level interrupts
// - Source bit picks default or previous value
// - Bank one: ports split at 0x00, 0x10
// - Bank zero: port registers interleaved, to 0x15
// - Bank change applies after byte; pointer untouched
// - Mirror ORs both ports onto both pins
// - Sequential disable freezes pointer, else increments
// - Slew disable clear enables data slew control
// - Serial variant, enable set: use address pins
// - Serial variant, enable clear: address zero
// - Two-wire variant always uses address pins
// - Open-drain bit overrides polarity, drives open-drain
// - Push-pull polarity bit selects active high
// - Only input pins raise change interrupts
// - Interrupt copies port value into capture
// - Capture or port read clears; writes don't
`timescale 1ns/1ns
`default_nettype none
module ioc_config_control #(
  parameter bit IS_SPI_VARIANT = 1'b1
) (
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Byte access from the serial front end
  input wire logic i_ptr_load,
  input wire logic [ioc_pkg::ADDR_WIDTH-1:0] i_ptr_value,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_rd_lsb_done,
  input wire logic i_byte_done,
  output logic [7:0] o_reg_rdata,
  output logic [ioc_pkg::ADDR_WIDTH-1:0] o_ptr,
  // Port pins and direction
  input wire logic [ioc_pkg::PORT_COUNT*ioc_pkg::PORT_WIDTH-1:0] i_port_pins,
  input wire logic [ioc_pkg::PORT_COUNT*ioc_pkg::PORT_WIDTH-1:0] i_pin_is_input,
  // Address pins
  input wire logic i_address_pin_2,
  input wire logic i_address_pin_1,
  input wire logic i_address_pin_0,
  output logic [2:0] o_hw_address,
  // Data line slew control
  output logic o_sda_slew_enable,
  // Interrupt pins
  output logic o_first_port_interrupt_pin_o,
  output logic o_first_port_interrupt_pin_oe,
  output logic o_second_port_interrupt_pin_o,
  output logic o_second_port_interrupt_pin_oe
);

  // Short names for the port geometry, used in every slice below
  localparam int unsigned W = ioc_pkg::PORT_WIDTH;
  localparam int unsigned NP = ioc_pkg::PORT_COUNT;

  // Map an address to port and register index for the given bank mode
  // Both maps share one index space, so the rest of the block never
  // needs to know which bank mode is active
  function automatic ioc_pkg::reg_sel_type decode_addr(
    input logic [ioc_pkg::ADDR_WIDTH-1:0] addr,
    input logic bank
  );
    ioc_pkg::reg_sel_type sel;
    sel = '0;
    if (bank) begin
      sel.port = addr[4];
      sel.index = addr[3:0];
      sel.valid = (addr[3:0] <= ioc_pkg::IDX_LAST);
    end else begin
      sel.port = addr[0];
      sel.index = {1'b0, addr[3:1]} | {addr[4], 3'h0};
      sel.valid = (addr <= ioc_pkg::BANK0_LAST_ADDR);
    end
    return sel;
  endfunction : decode_addr

  // True when the selection is a mapped slot holding the given register
  function automatic logic selects(
    input ioc_pkg::reg_sel_type s,
    input logic [3:0] idx
  );
    return s.valid && (s.index == idx);
  endfunction : selects

  // Pad drive for one interrupt pin, as {level, output enable}
  // Open drain only ever pulls low, so the polarity bit has no say there
  function automatic logic [1:0] pin_drive(
    input logic active,
    input ioc_pkg::config_type cfg
  );
    logic [1:0] drive;
    if (cfg.open_drain_bit) begin
      drive = {1'b0, active};
    end else begin
      drive = {active ~^ cfg.interrupt_polarity_bit, 1'b1};
    end
    return drive;
  endfunction : pin_drive

  // Slave address to match; the serial-peripheral variant may ignore its straps
  function automatic logic [2:0] address_choice(
    input logic [2:0] straps,
    input logic enable_bit
  );
    logic [2:0] chosen;
    chosen = straps;
    if (IS_SPI_VARIANT && !enable_bit) begin
      chosen = ioc_pkg::HW_ADDRESS_ZERO;
    end
    return chosen;
  endfunction : address_choice

  // Pin synchronisers; stage one is read by stage two only
  logic [NP*W-1:0] pins_meta_q;
  logic [NP*W-1:0] pins_q;
  logic [2:0] addr_meta_q;
  logic [2:0] addr_q;

  // Register state
  logic [ioc_pkg::ADDR_WIDTH-1:0] ptr_q;
  ioc_pkg::config_type config_q;
  logic [NP-1:0][W-1:0] enable_q;
  logic [NP-1:0][W-1:0] default_q;
  logic [NP-1:0][W-1:0] source_q;
  logic [7:0] rdata_q;
  logic [NP-1:0] int_o_q;
  logic [NP-1:0] int_oe_q;
  logic [2:0] hw_address_q;
  logic slew_enable_q;

  // Per-port results
  logic [NP-1:0][W-1:0] flags;
  logic [NP-1:0][W-1:0] capture;
  logic [NP-1:0] port_irq;
  logic [NP-1:0] port_clear;
  logic [NP-1:0] pin_active;

  ioc_pkg::reg_sel_type sel;
  logic [7:0] read_mux;

  // Decode follows the live bank bit, so a remap takes effect on the next access
  assign sel = decode_addr(ptr_q, config_q.bank);

  // Two-stage sampling of asynchronous pins
  // Costs two edges of latency on every pin change, traded for a settled level
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pins_meta_q <= '0;
      pins_q <= '0;
      addr_meta_q <= ioc_pkg::HW_ADDRESS_ZERO;
      addr_q <= ioc_pkg::HW_ADDRESS_ZERO;
    end else if (i_clk_en) begin
      pins_meta_q <= i_port_pins;
      pins_q <= pins_meta_q;
      addr_meta_q <= {i_address_pin_2, i_address_pin_1, i_address_pin_0};
      addr_q <= addr_meta_q;
    end
  end

  // Address pointer: load from the front end, then step per byte unless frozen
  // A load wins over a step so a new command always starts where it was aimed
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ptr_q <= '0;
    end else if (i_clk_en) begin
      if (i_ptr_load) begin
        ptr_q <= i_ptr_value;
      end else if (i_byte_done && !config_q.sequential_disable_bit) begin
        ptr_q <= ptr_q + ioc_pkg::POINTER_STEP;
      end
    end
  end

  // Configuration register, shared by both ports' slots
  // A bank change remaps at once but leaves the pointer where it is,
  // so a following auto-step can land on an unmapped slot
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      config_q <= ioc_pkg::CONFIG_RESET;
    end else if (i_clk_en) begin
      if (i_reg_wr && selects(sel, ioc_pkg::IDX_CONFIG)) begin
        config_q <= i_reg_wdata & ioc_pkg::CONFIG_WRITE_MASK;
      end
    end
  end

  // Per-port change-interrupt setup registers
  // Writes to read-only or foreign slots fall through the default branch; unmapped slots never reach the case
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      enable_q <= {NP{ioc_pkg::ENABLE_RESET}};
      default_q <= {NP{ioc_pkg::DEFAULT_RESET}};
      source_q <= {NP{ioc_pkg::SOURCE_RESET}};
    end else if (i_clk_en && i_reg_wr && sel.valid) begin
      case (sel.index)
        ioc_pkg::IDX_ENABLE: begin
          enable_q[sel.port] <= i_reg_wdata;
        end
        ioc_pkg::IDX_DEFAULT: begin
          default_q[sel.port] <= i_reg_wdata;
        end
        ioc_pkg::IDX_SOURCE: begin
          source_q[sel.port] <= i_reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Read multiplexer; unmapped slots and foreign registers read zero
  // Reading zero keeps a stray pointer after a remap harmless to the host
  always_comb begin
    read_mux = ioc_pkg::READ_ZERO;
    if (sel.valid) begin
      case (sel.index)
        ioc_pkg::IDX_ENABLE: begin
          read_mux = enable_q[sel.port];
        end
        ioc_pkg::IDX_DEFAULT: begin
          read_mux = default_q[sel.port];
        end
        ioc_pkg::IDX_SOURCE: begin
          read_mux = source_q[sel.port];
        end
        ioc_pkg::IDX_CONFIG: begin
          read_mux = config_q & ioc_pkg::CONFIG_WRITE_MASK;
        end
        ioc_pkg::IDX_FLAG: begin
          read_mux = flags[sel.port];
        end
        ioc_pkg::IDX_CAPTURE: begin
          read_mux = capture[sel.port];
        end
        ioc_pkg::IDX_PORT: begin
          read_mux = pins_q[sel.port*W +: W];
        end
        default: begin
          read_mux = ioc_pkg::READ_ZERO;
        end
      endcase
    end
  end

  // Read data follows the pointer one cycle later
  // The front end must allow that cycle before it shifts the byte out
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= ioc_pkg::READ_ZERO;
    end else if (i_clk_en) begin
      rdata_q <= read_mux;
    end
  end

  // Per-port event logic; clear only on the read's last bit, never on a write
  generate
    for (genvar p = 0; p < NP; p++) begin : g_port
      ioc_pkg::port_cfg_type cfg;
      assign cfg.enable = enable_q[p];
      assign cfg.default_value = default_q[p];
      assign cfg.source = source_q[p];
      // Only the capture or port slot of this very port clears it
      assign port_clear[p] = i_rd_lsb_done && (sel.port == 1'(p)) &&
                             (selects(sel, ioc_pkg::IDX_CAPTURE) || selects(sel, ioc_pkg::IDX_PORT));

      ioc_port_events u_events (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_clk_en(i_clk_en),
        .i_cfg(cfg),
        .i_pin_level(pins_q[p*W +: W]),
        .i_pin_is_input(i_pin_is_input[p*W +: W]),
        .i_clear(port_clear[p]),
        .o_flags(flags[p]),
        .o_capture(capture[p]),
        .o_irq(port_irq[p])
      );

      // Mirroring ORs both ports so either pin reports any port
      assign pin_active[p] = config_q.mirror ? (|port_irq) : port_irq[p];
    end
  endgenerate

  // Interrupt pin drivers, registered so the pads never see decode glitches
  // Reset leaves both pins inactive for the default active-low push-pull setup
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_o_q <= '1;
      int_oe_q <= '1;
    end else if (i_clk_en) begin
      for (int p = 0; p < NP; p++) begin
        {int_o_q[p], int_oe_q[p]} <= pin_drive(pin_active[p], config_q);
      end
    end
  end

  // Slave address and slew control follow configuration
  // Both settle one edge after the configuration write that changes them
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hw_address_q <= ioc_pkg::HW_ADDRESS_ZERO;
      slew_enable_q <= 1'b0;
    end else if (i_clk_en) begin
      hw_address_q <= address_choice(addr_q, config_q.hw_address_enable_bit);
      slew_enable_q <= !config_q.slew_disable_bit;
    end
  end

  // Every output comes straight from a register
  assign o_reg_rdata = rdata_q;
  assign o_ptr = ptr_q;
  assign o_hw_address = hw_address_q;
  assign o_sda_slew_enable = slew_enable_q;
  assign o_first_port_interrupt_pin_o = int_o_q[0];
  assign o_first_port_interrupt_pin_oe = int_oe_q[0];
  assign o_second_port_interrupt_pin_o = int_o_q[1];
  assign o_second_port_interrupt_pin_oe = int_oe_q[1];

endmodule : ioc_config_control
`default_nettype wire

// >>> verification/ioc_config_control_sva.sv
`timescale 1ns/1ns
`default_nettype none
module ioc_checker #(
  parameter bit IS_SPI_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Byte access
  input wire logic i_ptr_load,
  input wire logic [4:0] i_ptr_value,
  input wire logic i_reg_wr,
  input wire logic i_byte_done,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [4:0] o_ptr,
  // Address, slew and interrupt pins
  input wire logic i_address_pin_2,
  input wire logic i_address_pin_1,
  input wire logic i_address_pin_0,
  input wire logic [2:0] o_hw_address,
  input wire logic o_sda_slew_enable,
  input wire logic o_first_port_interrupt_pin_o,
  input wire logic o_first_port_interrupt_pin_oe,
  input wire logic o_second_port_interrupt_pin_o,
  input wire logic o_second_port_interrupt_pin_oe
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  // Steps of a pointer move and of a settled address strap
  sequence load_s;
    i_clk_en && i_ptr_load;
  endsequence
  sequence step_s;
    i_clk_en && !i_ptr_load && i_byte_done;
  endsequence
  sequence pins_still_s;
    $stable({i_address_pin_2, i_address_pin_1, i_address_pin_0})[*4];
  endsequence
  ptr_load_a: assert property (load_s |=> o_ptr == $past(i_ptr_value))
    else $error("pointer load not applied");
  ptr_step_a: assert property (step_s |=> o_ptr == $past(o_ptr) || o_ptr == $past(o_ptr) + 5'h01)
    else $error("pointer moved by other than zero or one");
  unmapped_zero_a: assert property (i_clk_en && o_ptr >= 5'h1b |=> o_reg_rdata == 8'h00)
    else $error("unmapped address read nonzero");
  cfg_bit_zero_a: assert property (i_clk_en && (o_ptr == 5'h0a || o_ptr == 5'h0b) |=> !o_reg_rdata[0])
    else $error("configuration bit zero read as one");
  hw_addr_a: assert property (pins_still_s |->
    o_hw_address == {i_address_pin_2, i_address_pin_1, i_address_pin_0} || (IS_SPI_VARIANT && o_hw_address == 3'h0))
    else $error("hardware address neither pins nor zero");
  drain_first_a: assert property (!(o_first_port_interrupt_pin_o && !o_first_port_interrupt_pin_oe))
    else $error("first interrupt pin high while released");
  drain_second_a: assert property (!(o_second_port_interrupt_pin_o && !o_second_port_interrupt_pin_oe))
    else $error("second interrupt pin high while released");
  reset_int_a: assert property ($rose(i_rst_b) |->
    o_first_port_interrupt_pin_o && o_first_port_interrupt_pin_oe && o_second_port_interrupt_pin_o
    && o_second_port_interrupt_pin_oe)
    else $error("interrupt pins not inactive after reset");
  // Slew control only moves after a register write, apart from its first step out of reset
  slew_write_a: assert property ($changed(o_sda_slew_enable) && $past(i_rst_b, 2) |->
    $past(i_reg_wr) || $past(i_reg_wr, 2))
    else $error("slew control changed without a write");
endmodule : ioc_checker
bind ioc_config_control ioc_checker #(.IS_SPI_VARIANT(IS_SPI_VARIANT)) ioc_checker_inst (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en), .i_ptr_load(i_ptr_load),
  .i_ptr_value(i_ptr_value), .i_reg_wr(i_reg_wr), .i_byte_done(i_byte_done), .o_reg_rdata(o_reg_rdata),
  .o_ptr(o_ptr), .i_address_pin_2(i_address_pin_2), .i_address_pin_1(i_address_pin_1),
  .i_address_pin_0(i_address_pin_0), .o_hw_address(o_hw_address), .o_sda_slew_enable(o_sda_slew_enable),
  .o_first_port_interrupt_pin_o(o_first_port_interrupt_pin_o),
  .o_first_port_interrupt_pin_oe(o_first_port_interrupt_pin_oe),
  .o_second_port_interrupt_pin_o(o_second_port_interrupt_pin_o),
  .o_second_port_interrupt_pin_oe(o_second_port_interrupt_pin_oe));
`default_nettype wire

// >>> verification/ioc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module ioc_host_model (
  // Clock
  input wire logic i_core_clk,
  // Byte access requests
  output logic o_ptr_load,
  output logic [4:0] o_ptr_value,
  output logic o_reg_wr,
  output logic [7:0] o_reg_wdata,
  output logic o_rd_lsb_done,
  output logic o_byte_done,
  // Read data
  input wire logic [7:0] i_reg_rdata
);
  // Idle levels; qualifiers show junk when no strobe is up
  initial begin
    o_ptr_load = 1'b0;
    o_ptr_value = 5'h1f;
    o_reg_wr = 1'b0;
    o_reg_wdata = 8'hff;
    o_rd_lsb_done = 1'b0;
    o_byte_done = 1'b0;
  end
  // Pointer load, taken at the next edge
  task automatic aim(input logic [4:0] a);
    o_ptr_load = 1'b1;
    o_ptr_value = a;
    @(posedge i_core_clk);
    #1;
    o_ptr_load = 1'b0;
    o_ptr_value = ~a;
  endtask : aim
  // One byte per write so a bank change never strands a burst
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    aim(a);
    o_reg_wr = 1'b1;
    o_reg_wdata = d;
    o_byte_done = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_reg_wr = 1'b0;
    o_byte_done = 1'b0;
    o_reg_wdata = ~d;
  endtask : wr
  // Read: data settles one cycle after the pointer, then the last bit leaves
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    aim(a);
    @(posedge i_core_clk);
    #1;
    d = i_reg_rdata;
    o_rd_lsb_done = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_rd_lsb_done = 1'b0;
  endtask : rd
endmodule : ioc_host_model
`default_nettype wire

// >>> verification/ioc_config_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module ioc_config_control_bench;
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [15:0] pins = 16'h0000;
  logic [15:0] is_in = 16'hffff;
  logic [2:0] apins = 3'h5;
  logic en = 1'b1;
  logic ld, wr, lsb, bd;
  logic [4:0] pv, o_ptr;
  logic [7:0] wd, rdata, d;
  logic [2:0] hw;
  logic slew, fo, foe, so, soe;
  wire [3:0] irq = {fo, foe, so, soe};
  int err_total = 0;
  int checks = 0;
  // Clock
  always #5 i_core_clk = ~i_core_clk;
  ioc_host_model ioc_host_model_inst (.i_core_clk(i_core_clk), .o_ptr_load(ld), .o_ptr_value(pv),
    .o_reg_wr(wr), .o_reg_wdata(wd), .o_rd_lsb_done(lsb), .o_byte_done(bd), .i_reg_rdata(rdata));
  ioc_config_control ioc_config_control_inst (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_clk_en(en),
    .i_ptr_load(ld), .i_ptr_value(pv), .i_reg_wr(wr), .i_reg_wdata(wd), .i_rd_lsb_done(lsb),
    .i_byte_done(bd), .o_reg_rdata(rdata), .o_ptr(o_ptr), .i_port_pins(pins), .i_pin_is_input(is_in),
    .i_address_pin_2(apins[2]), .i_address_pin_1(apins[1]), .i_address_pin_0(apins[0]),
    .o_hw_address(hw), .o_sda_slew_enable(slew), .o_first_port_interrupt_pin_o(fo),
    .o_first_port_interrupt_pin_oe(foe), .o_second_port_interrupt_pin_o(so),
    .o_second_port_interrupt_pin_oe(soe));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("errors=%0d checks=%0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // Bounded wait on the first interrupt pin level
  task automatic wait_first(input logic lvl);
    int n;
    n = 0;
    while (fo !== lvl && n < 20) begin
      @(posedge i_core_clk);
      #1;
      n++;
    end
    if (fo !== lvl) begin
      err_total++;
      summarize();
    end
  endtask : wait_first
  // Setup registers come up cleared, pins inactive high, active-low push-pull
  task automatic t_reset();
    chk({4'h0, irq}, 8'h0f);
    for (int a = 4; a < 12; a++) begin
      ioc_host_model_inst.rd(a[4:0], d);
      chk(d, 8'h00);
    end
  endtask : t_reset
  // Configuration fields reach their pins; pointer follows the freeze bit
  task automatic t_config();
    ioc_host_model_inst.wr(5'h0a, 8'h7f);
    chk({3'h0, o_ptr}, 8'h0b);
    ioc_host_model_inst.rd(5'h0a, d);
    chk(d, 8'h7e);
    chk({7'h0, slew}, 8'h00);
    chk({5'h0, hw}, 8'h05);
    chk({4'h0, irq}, 8'h00);
    ioc_host_model_inst.wr(5'h0a, 8'h02);
    chk({3'h0, o_ptr}, 8'h0a);
    ioc_host_model_inst.rd(5'h0b, d);
    chk(d, 8'h02);
    chk({4'h0, irq}, 8'h05);
    chk({5'h0, hw}, 8'h00);
    chk({7'h0, slew}, 8'h01);
    ioc_host_model_inst.wr(5'h0a, 8'h00);
  endtask : t_config
  // Default compare on the first port; a disabled pin rides along in the capture
  task automatic t_default();
    ioc_host_model_inst.wr(5'h06, 8'h00);
    ioc_host_model_inst.wr(5'h08, 8'h01);
    ioc_host_model_inst.wr(5'h04, 8'h01);
    pins[1:0] = 2'h3;
    wait_first(1'b0);
    chk({4'h0, irq}, 8'h07);
    ioc_host_model_inst.wr(5'h0a, 8'h04);
    @(posedge i_core_clk);
    #1;
    chk({4'h0, irq}, 8'h04);
    ioc_host_model_inst.wr(5'h0a, 8'h02);
    @(posedge i_core_clk);
    #1;
    chk({4'h0, irq}, 8'h0d);
    ioc_host_model_inst.wr(5'h0a, 8'h00);
    pins[1:0] = 2'h0;
    ioc_host_model_inst.wr(5'h12, 8'hff);
    chk({4'h0, irq}, 8'h07);
    ioc_host_model_inst.rd(5'h0e, d);
    chk(d, 8'h01);
    ioc_host_model_inst.rd(5'h10, d);
    chk(d, 8'h03);
    repeat (2) @(posedge i_core_clk);
    #1;
    chk({4'h0, irq}, 8'h0f);
  endtask : t_default
  // Previous-value compare on the second port, mirrored; output pins stay quiet
  task automatic t_mirror();
    ioc_host_model_inst.wr(5'h0a, 8'h40);
    ioc_host_model_inst.wr(5'h07, 8'h00);
    ioc_host_model_inst.wr(5'h09, 8'h00);
    ioc_host_model_inst.wr(5'h05, 8'h80);
    pins[15] = 1'b1;
    wait_first(1'b0);
    chk({4'h0, irq}, 8'h05);
    ioc_host_model_inst.rd(5'h13, d);
    chk(d, 8'h80);
    repeat (2) @(posedge i_core_clk);
    #1;
    chk({4'h0, irq}, 8'h0f);
    is_in[15] = 1'b0;
    pins[15] = 1'b0;
    repeat (8) begin
      @(posedge i_core_clk);
      #1;
      chk({4'h0, irq}, 8'h0f);
    end
  endtask : t_mirror
  // Bank change leaves the pointer on a dead slot, then the split map holds
  task automatic t_bank();
    ioc_host_model_inst.wr(5'h0a, 8'h80);
    chk({3'h0, o_ptr}, 8'h0b);
    @(posedge i_core_clk);
    #1;
    chk(rdata, 8'h00);
    ioc_host_model_inst.rd(5'h05, d);
    chk(d, 8'h80);
    ioc_host_model_inst.rd(5'h02, d);
    chk(d, 8'h01);
    ioc_host_model_inst.rd(5'h12, d);
    chk(d, 8'h80);
    ioc_host_model_inst.rd(5'h1c, d);
    chk(d, 8'h00);
  endtask : t_bank
  // Clock enable low freezes pointer and registers; strobes in that time are lost
  task automatic t_freeze();
    en = 1'b0;
    ioc_host_model_inst.wr(5'h05, 8'h00);
    chk({3'h0, o_ptr}, 8'h1c);
    en = 1'b1;
    ioc_host_model_inst.rd(5'h05, d);
    chk(d, 8'h80);
  endtask : t_freeze
  // Main sequence
  initial begin
    repeat (6) @(posedge i_core_clk);
    #1;
    i_rst_b = 1'b1;
    t_reset();
    t_config();
    t_default();
    t_mirror();
    t_bank();
    t_freeze();
    summarize();
  end
endmodule : ioc_config_control_bench
`default_nettype wire
